// ==== logic/srd_consts.vh ====
// Register offsets, status bit positions and decode constants for the slot register decode
`ifndef SRD_CONSTS_VH
`define SRD_CONSTS_VH

`define SRD_ADDR_W          20
`define SRD_OFF_STATUS      20'h00000
`define SRD_OFF_CMD1        20'h00000
`define SRD_OFF_CMD2        20'h00004
`define SRD_OFF_SCANCNT     20'h00008
`define SRD_OFF_CHGAIN      20'h0000C
`define SRD_OFF_CONVSTART   20'h00010
`define SRD_OFF_ACQSTART    20'h00014
`define SRD_OFF_ACQCLEAR    20'h00018
`define SRD_OFF_EXTSEL      20'h0001C
`define SRD_OFF_AOUTA       20'h00020
`define SRD_OFF_AOUTB       20'h00024
`define SRD_OFF_FIFO        20'h0002C
`define SRD_OFF_CTRDATA     20'h00030
`define SRD_OFF_CTRCMD      20'h00034
`define SRD_OFF_DIO         20'h00038
`define SRD_OFF_SELFCAL     20'h20000
`define SRD_OFF_TMRCLR      20'h40000
`define SRD_OFF_TSWSHIFT    20'hC0000
`define SRD_OFF_TSWLOAD     20'hC0004

`define SRD_ST_INT_N        15
`define SRD_ST_COMPLETE     14
`define SRD_ST_AVAIL        13
`define SRD_ST_RUN          11
`define SRD_ST_OVERFLOW     9
`define SRD_ST_OVERRUN      8
`define SRD_ST_TIMER        5

`define SRD_C1_TMRINTEN     13
`define SRD_C1_RUN_COMPLETE_IRQ_ENABLE    7
`define SRD_C1_RESULT_IRQ_ENABLE    6

`define SRD_UNMAPPED_DATA   16'h0000
`define SRD_RESET_WORD      16'h0000
`define SRD_NUM_STROBES     13

`endif

// ==== logic/srd_event_flag.v ====
// Sticky event flag with set priority over clear
`timescale 1ns/1ps
module srd_event_flag (
    // Clock and reset
    input  wire core_clk,
    input  wire resetn,
    // Event and clear
    input  wire set_evt,
    input  wire clr_evt,
    // Flag
    output reg  flag
);
    // Set wins so an event landing on the clear cycle is kept
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            flag <= 1'b0;
        else if (set_evt)
            flag <= 1'b1;
        else if (clr_evt)
            flag <= 1'b0;
    end
endmodule // srd_event_flag

// ==== logic/srd_rise_detect.v ====
// Rising edge detector for a synchronous level input
`timescale 1ns/1ps
module srd_rise_detect (
    // Clock and reset
    input  wire core_clk,
    input  wire resetn,
    // Level in, pulse out
    input  wire level_in,
    output wire rise_pulse
);
    reg level_d;
    reg armed;

    // First sample after reset only primes the history, so a level that
    // idles high is not taken for a rising edge
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            level_d <= 1'b0;
            armed   <= 1'b0;
        end else begin
            level_d <= level_in;
            armed   <= 1'b1;
        end
    end

    assign rise_pulse = level_in & ~level_d & armed;
endmodule // srd_rise_detect

// ==== logic/srd_slot_register_decode.v ====
// Slot register decode: address map, write registers, strobes and status word
`timescale 1ns/1ps
`include "srd_consts.vh"
module srd_slot_register_decode #(
    parameter SLOT_ADDR_W = 32
) (
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   resetn,
    // Host register port
    input  wire [SLOT_ADDR_W-1:0] host_addr,
    input  wire                   host_wr,
    input  wire                   host_rd,
    input  wire [1:0]             host_byte_en,
    input  wire [15:0]            host_wdata,
    output reg  [15:0]            host_rdata,
    // Board state inputs
    input  wire                   fifo_not_empty,
    input  wire                   internal_run_active,
    input  wire                   run_done_evt,
    input  wire                   fifo_overflow_evt,
    input  wire                   convert_overrun_evt,
    input  wire                   counter_two_output,
    input  wire [1:0]             gain_state,
    input  wire [1:0]             mux_enable_state,
    input  wire [2:0]             mux_address_state,
    input  wire [15:0]            fifo_rdata,
    input  wire [15:0]            counter_chip_rdata,
    input  wire [15:0]            counter_chip_status,
    input  wire [15:0]            digital_in_lines,
    // Write register contents
    output reg  [15:0]            command_word_one,
    output reg  [15:0]            command_word_two,
    output reg  [15:0]            scan_counter_load,
    output reg  [15:0]            channel_gain_entry,
    output reg  [15:0]            analog_out_a,
    output reg  [15:0]            analog_out_b,
    output reg  [15:0]            counter_chip_wdata,
    output reg  [15:0]            counter_chip_command,
    output reg  [15:0]            digital_out_lines,
    output reg  [7:0]             trigger_switch_data,
    // One-cycle event strobes
    output wire                   conversion_start_strobe,
    output wire                   acquisition_start_strobe,
    output wire                   acquisition_clear_strobe,
    output wire                   ext_selector_strobe,
    output wire                   self_calibration_strobe,
    output wire                   timer_irq_clear_strobe,
    output wire                   trigger_switch_load,
    output wire                   fifo_pop,
    output wire                   counter_chip_data_rd,
    output wire                   counter_chip_data_wr,
    output wire                   counter_chip_cmd_wr,
    // Interrupt request, negative logic
    output wire                   board_irq_n
);
    // Only the low 20 address bits select a register; the slot digit that the
    // short mode puts in bits 23:20 is ignored, so Fss0 0000 reaches the map
    wire [`SRD_ADDR_W-1:0] off = host_addr[`SRD_ADDR_W-1:0];

    wire hit_cmd1     = (off == `SRD_OFF_CMD1);
    wire hit_cmd2     = (off == `SRD_OFF_CMD2);
    wire hit_scancnt  = (off == `SRD_OFF_SCANCNT);
    wire hit_chgain   = (off == `SRD_OFF_CHGAIN);
    wire hit_convst   = (off == `SRD_OFF_CONVSTART);
    wire hit_acqst    = (off == `SRD_OFF_ACQSTART);
    wire hit_acqclr   = (off == `SRD_OFF_ACQCLEAR);
    wire hit_extsel   = (off == `SRD_OFF_EXTSEL);
    wire hit_aouta    = (off == `SRD_OFF_AOUTA);
    wire hit_aoutb    = (off == `SRD_OFF_AOUTB);
    wire hit_fifo     = (off == `SRD_OFF_FIFO);
    wire hit_ctrdata  = (off == `SRD_OFF_CTRDATA);
    wire hit_ctrcmd   = (off == `SRD_OFF_CTRCMD);
    wire hit_dio      = (off == `SRD_OFF_DIO);
    wire hit_selfcal  = (off == `SRD_OFF_SELFCAL);
    wire hit_tmrclr   = (off == `SRD_OFF_TMRCLR);
    wire hit_tswshift = (off == `SRD_OFF_TSWSHIFT);
    wire hit_tswload  = (off == `SRD_OFF_TSWLOAD);

    // A write strobe fires on a write of any width, fifo_pop and counter_chip_data_rd on any read; the data lanes are not looked at
    wire wr_any = host_wr & (|host_byte_en);
    wire [`SRD_NUM_STROBES-1:0] strobe_hit = {
        hit_convst, hit_acqst, hit_acqclr, hit_extsel, hit_selfcal,
        hit_tmrclr, hit_tswload, hit_fifo, hit_ctrdata, hit_ctrdata,
        hit_ctrcmd, hit_aouta, hit_aoutb};
    wire [`SRD_NUM_STROBES-1:0] strobe_req = {
        {7{wr_any}}, host_rd, host_rd, wr_any, wr_any, wr_any, wr_any};
    wire [`SRD_NUM_STROBES-1:0] strobe_vec;
    genvar gi;
    generate
        for (gi = 0; gi < `SRD_NUM_STROBES; gi = gi + 1) begin : g_strobe
            assign strobe_vec[gi] = strobe_hit[gi] & strobe_req[gi];
        end
    endgenerate

    wire dac_a_wr = strobe_vec[1];
    wire dac_b_wr = strobe_vec[0];
    assign conversion_start_strobe  = strobe_vec[12];
    assign acquisition_start_strobe = strobe_vec[11];
    assign acquisition_clear_strobe = strobe_vec[10];
    assign ext_selector_strobe      = strobe_vec[9];
    assign self_calibration_strobe  = strobe_vec[8];
    assign timer_irq_clear_strobe   = strobe_vec[7];
    assign trigger_switch_load      = strobe_vec[6];
    assign fifo_pop                 = strobe_vec[5];
    assign counter_chip_data_rd     = strobe_vec[4];
    assign counter_chip_data_wr     = strobe_vec[3];
    assign counter_chip_cmd_wr      = strobe_vec[2];

    // Lane enables; a write with no lane set changes no register
    wire wr_hi = host_wr & host_byte_en[1];
    wire wr_lo = host_wr & host_byte_en[0];

    // Command words; the write side of offset zero lands here, not in status
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            command_word_one <= `SRD_RESET_WORD;
        else if (hit_cmd1) begin
            if (wr_hi)
                command_word_one[15:8] <= host_wdata[15:8];
            if (wr_lo)
                command_word_one[7:0] <= host_wdata[7:0];
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            command_word_two <= `SRD_RESET_WORD;
        else if (hit_cmd2) begin
            if (wr_hi)
                command_word_two[15:8] <= host_wdata[15:8];
            if (wr_lo)
                command_word_two[7:0] <= host_wdata[7:0];
        end
    end

    // Scan setup
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            scan_counter_load <= `SRD_RESET_WORD;
        else if (hit_scancnt) begin
            if (wr_hi)
                scan_counter_load[15:8] <= host_wdata[15:8];
            if (wr_lo)
                scan_counter_load[7:0] <= host_wdata[7:0];
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            channel_gain_entry <= `SRD_RESET_WORD;
        else if (hit_chgain) begin
            if (wr_hi)
                channel_gain_entry[15:8] <= host_wdata[15:8];
            if (wr_lo)
                channel_gain_entry[7:0] <= host_wdata[7:0];
        end
    end

    // Analog outputs
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            analog_out_a <= `SRD_RESET_WORD;
        else if (hit_aouta) begin
            if (wr_hi)
                analog_out_a[15:8] <= host_wdata[15:8];
            if (wr_lo)
                analog_out_a[7:0] <= host_wdata[7:0];
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            analog_out_b <= `SRD_RESET_WORD;
        else if (hit_aoutb) begin
            if (wr_hi)
                analog_out_b[15:8] <= host_wdata[15:8];
            if (wr_lo)
                analog_out_b[7:0] <= host_wdata[7:0];
        end
    end

    // Counter chip words; reads of these offsets come from the chip itself
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            counter_chip_wdata <= `SRD_RESET_WORD;
        else if (hit_ctrdata) begin
            if (wr_hi)
                counter_chip_wdata[15:8] <= host_wdata[15:8];
            if (wr_lo)
                counter_chip_wdata[7:0] <= host_wdata[7:0];
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            counter_chip_command <= `SRD_RESET_WORD;
        else if (hit_ctrcmd) begin
            if (wr_hi)
                counter_chip_command[15:8] <= host_wdata[15:8];
            if (wr_lo)
                counter_chip_command[7:0] <= host_wdata[7:0];
        end
    end

    // Digital output lines; the read side of this offset is the input lines
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            digital_out_lines <= `SRD_RESET_WORD;
        else if (hit_dio) begin
            if (wr_hi)
                digital_out_lines[15:8] <= host_wdata[15:8];
            if (wr_lo)
                digital_out_lines[7:0] <= host_wdata[7:0];
        end
    end

    // Byte register sits on the low lane; host is expected to use byte writes
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            trigger_switch_data <= 8'h00;
        else if (hit_tswshift) begin
            if (wr_lo)
                trigger_switch_data <= host_wdata[7:0];
        end
    end

    // Sticky status flags
    wire counter_two_rise;
    wire run_complete_flag;
    wire timer_edge_flag;
    wire overflow_flag;
    wire overrun_flag;

    srd_rise_detect u_ctr2_edge (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .level_in   (counter_two_output),
        .rise_pulse (counter_two_rise)
    );

    srd_event_flag u_complete (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set_evt  (run_done_evt),
        .clr_evt  (acquisition_clear_strobe),
        .flag     (run_complete_flag)
    );

    srd_event_flag u_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set_evt  (counter_two_rise),
        .clr_evt  (timer_irq_clear_strobe | dac_a_wr | dac_b_wr),
        .flag     (timer_edge_flag)
    );

    srd_event_flag u_overflow (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set_evt  (fifo_overflow_evt),
        .clr_evt  (acquisition_clear_strobe),
        .flag     (overflow_flag)
    );

    srd_event_flag u_overrun (
        .core_clk (core_clk),
        .resetn   (resetn),
        .set_evt  (convert_overrun_evt),
        .clr_evt  (acquisition_clear_strobe),
        .flag     (overrun_flag)
    );

    wire run_complete_irq_enable = command_word_one[`SRD_C1_RUN_COMPLETE_IRQ_ENABLE];
    wire result_irq_enable       = command_word_one[`SRD_C1_RESULT_IRQ_ENABLE];
    wire timer_irq_enable        = command_word_one[`SRD_C1_TMRINTEN];
    wire result_available_flag   = fifo_not_empty;
    wire run_in_progress_flag    = internal_run_active;

    // Completion only counts as a request when its enable is set
    wire complete_req = run_complete_flag & run_complete_irq_enable;
    wire result_req   = result_available_flag & result_irq_enable;
    wire timer_req    = timer_edge_flag & timer_irq_enable;
    wire irq_req      = complete_req | result_req | timer_req;
    assign board_irq_n = ~irq_req;

    // Status word; unused bits 12 and 10 read zero
    wire [15:0] status_word;
    assign status_word[`SRD_ST_INT_N]    = ~irq_req;
    assign status_word[`SRD_ST_COMPLETE] = run_complete_flag;
    assign status_word[`SRD_ST_AVAIL]    = result_available_flag;
    assign status_word[12]               = 1'b0;
    assign status_word[`SRD_ST_RUN]      = run_in_progress_flag;
    assign status_word[10]               = 1'b0;
    assign status_word[`SRD_ST_OVERFLOW] = overflow_flag;
    assign status_word[`SRD_ST_OVERRUN]  = overrun_flag;
    assign status_word[7:6]              = gain_state;
    assign status_word[`SRD_ST_TIMER]    = timer_edge_flag;
    assign status_word[4:3]              = mux_enable_state;
    assign status_word[2:0]              = mux_address_state;

    // Reads and writes at offset zero reach different registers
    wire rd_status = (off == `SRD_OFF_STATUS);

    // Read mux; registered so read data stands one cycle after the request
    reg [15:0] next_rdata;
    always @* begin
        next_rdata = `SRD_UNMAPPED_DATA;
        if (rd_status)
            next_rdata = status_word;
        else if (hit_fifo)
            next_rdata = fifo_rdata;
        else if (hit_ctrdata)
            next_rdata = counter_chip_rdata;
        else if (hit_ctrcmd)
            next_rdata = counter_chip_status;
        else if (hit_dio)
            next_rdata = digital_in_lines;
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            host_rdata <= `SRD_RESET_WORD;
        else if (host_rd)
            host_rdata <= next_rdata;
    end
endmodule // srd_slot_register_decode

// ==== verification/srd_props.sv ====
// Assertion checker for the slot register decode ports
`timescale 1ns/1ps
module srd_props #(
    parameter SLOT_ADDR_W = 32
) (
    // Clock and reset
    input wire                   core_clk,
    input wire                   resetn,
    // Host port and watched state
    input wire [SLOT_ADDR_W-1:0] host_addr,
    input wire                   host_wr,
    input wire                   host_rd,
    input wire [1:0]             host_byte_en,
    input wire [15:0]            host_wdata,
    input wire [15:0]            host_rdata,
    input wire                   run_done_evt,
    input wire                   fifo_overflow_evt,
    input wire                   convert_overrun_evt,
    input wire                   internal_run_active,
    input wire [15:0]            digital_in_lines,
    input wire [15:0]            command_word_two,
    input wire                   acquisition_clear_strobe,
    input wire                   board_irq_n
);
    wire [19:0] off = host_addr[19:0];
    wire        quiet = !run_done_evt && !fifo_overflow_evt && !convert_overrun_evt;
    wire        stat_rd = host_rd && off == 20'h00000;
    wire        clr_wr = host_wr && host_byte_en != 2'b00 && off == 20'h00018;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // A set event in the same cycle would win over the clear
    sequence s_clr;
        clr_wr && quiet;
    endsequence
    sequence s_stat;
        stat_rd && quiet;
    endsequence
    property p_clr_stb;
        clr_wr |-> acquisition_clear_strobe;
    endproperty
    property p_no_stb;
        !host_wr |-> !acquisition_clear_strobe;
    endproperty
    property p_flags;
        s_clr ##1 s_stat |=> host_rdata[14] == 1'b0 && host_rdata[9:8] == 2'b00;
    endproperty
    property p_run;
        stat_rd |=> host_rdata[11] == $past(internal_run_active);
    endproperty
    property p_irq;
        stat_rd |=> host_rdata[15] == $past(board_irq_n);
    endproperty
    property p_dio;
        host_rd && off == 20'h00038 |=> host_rdata == $past(digital_in_lines);
    endproperty
    property p_unmap;
        host_rd && off == 20'h0003C |=> host_rdata == 16'h0000;
    endproperty
    property p_cmd2;
        host_wr && host_byte_en == 2'b11 && off == 20'h00004 |=> command_word_two == $past(host_wdata);
    endproperty
    a_clr_stb: assert property (p_clr_stb) else $error("clear write gave no strobe");
    a_no_stb: assert property (p_no_stb) else $error("strobe without a write");
    a_flags: assert property (p_flags) else $error("flags survive clear");
    a_run: assert property (p_run) else $error("run bit wrong");
    a_irq: assert property (p_irq) else $error("interrupt bit wrong");
    a_dio: assert property (p_dio) else $error("digital input read wrong");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_cmd2: assert property (p_cmd2) else $error("command word two not loaded");
endmodule // srd_props

// ==== verification/srd_host_model.sv ====
// Host model issuing single-cycle register accesses in the slot window
`timescale 1ns/1ps
module srd_host_model (
    // Clock and slot
    input  wire        core_clk,
    input  wire [3:0]  slot,
    // Host register port
    output reg  [31:0] host_addr = 32'h0000_0000,
    output reg         host_wr = 1'b0,
    output reg         host_rd = 1'b0,
    output reg  [1:0]  host_byte_en = 2'b00,
    output reg  [15:0] host_wdata = 16'h0000
);
    // Calls back to back keep the bus busy every cycle
    task acc(input [19:0] off, input w, input [1:0] be, input [15:0] d);
        begin
            @(posedge core_clk);
            host_addr <= {4'hF, slot, slot, off};
            host_wr <= w;
            host_rd <= ~w;
            host_byte_en <= be;
            host_wdata <= d;
        end
    endtask
    // Eight-bit registers take a byte access, upper lane junk
    task wr8(input [19:0] off, input [7:0] d);
        acc(off, 1'b1, 2'b01, {~d, d});
    endtask
    // Address and data lines carry the inverse of their last value; write, read and lane enables drop low
    task idle;
        begin
            @(posedge core_clk);
            host_wr <= 1'b0;
            host_rd <= 1'b0;
            host_byte_en <= 2'b00;
            host_addr <= ~host_addr;
            host_wdata <= ~host_wdata;
            @(negedge core_clk);
        end
    endtask
endmodule // srd_host_model

// ==== verification/testbench.sv ====
// Self-checking bench for the slot register decode
`timescale 1ns/1ps
module testbench;
    reg         core_clk = 1'b0, resetn = 1'b0, fne = 1'b0, run = 1'b0, c2 = 1'b0;
    reg  [2:0]  evt = 3'b000;
    reg  [6:0]  mg = 7'h00;
    reg  [15:0] fifo_d = 16'h0000, ctr_d = 16'h0000, ctr_s = 16'h0000, din = 16'h0000;
    reg  [3:0]  slot = 4'h0;
    reg  [10:0] stb_seen = 11'h000;
    reg         rd_pend = 1'b0;
    reg  [15:0] cmd1 = 16'h0000;
    reg  [3:0]  m_flag = 4'h0;
    reg  [31:0] exp_q[$];
    reg  [31:0] r;
    wire [31:0] host_addr;
    wire        host_wr, host_rd, board_irq_n;
    wire [1:0]  host_byte_en;
    wire [15:0] host_wdata, host_rdata;
    wire [15:0] wreg [0:8];
    wire [10:0] stb;
    wire [7:0]  tsw;
    integer     bad_count = 0, checks_done = 0, i;
    localparam [19:0] WOFF [0:8] = '{20'h0, 20'h4, 20'h8, 20'hC, 20'h20, 20'h24,
                                     20'h30, 20'h34, 20'h38};
    localparam [19:0] SOFF [0:10] = '{20'h10, 20'h14, 20'h18, 20'h1C, 20'h20000,
                                      20'h40000, 20'hC0004, 20'h2C, 20'h30, 20'h30, 20'h34};
    always #12.5 core_clk = ~core_clk;
    srd_host_model host_u (.core_clk(core_clk), .slot(slot), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_byte_en(host_byte_en),
        .host_wdata(host_wdata));
    srd_slot_register_decode dut_u (.core_clk(core_clk), .resetn(resetn),
        .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_byte_en(host_byte_en), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .fifo_not_empty(fne), .internal_run_active(run), .run_done_evt(evt[2]),
        .fifo_overflow_evt(evt[1]), .convert_overrun_evt(evt[0]), .counter_two_output(c2),
        .gain_state(mg[6:5]), .mux_enable_state(mg[4:3]), .mux_address_state(mg[2:0]),
        .fifo_rdata(fifo_d), .counter_chip_rdata(ctr_d), .counter_chip_status(ctr_s),
        .digital_in_lines(din), .command_word_one(wreg[0]), .command_word_two(wreg[1]),
        .scan_counter_load(wreg[2]), .channel_gain_entry(wreg[3]), .analog_out_a(wreg[4]),
        .analog_out_b(wreg[5]), .counter_chip_wdata(wreg[6]),
        .counter_chip_command(wreg[7]), .digital_out_lines(wreg[8]), .trigger_switch_data(tsw),
        .conversion_start_strobe(stb[10]), .acquisition_start_strobe(stb[9]),
        .acquisition_clear_strobe(stb[8]), .ext_selector_strobe(stb[7]),
        .self_calibration_strobe(stb[6]), .timer_irq_clear_strobe(stb[5]),
        .trigger_switch_load(stb[4]), .fifo_pop(stb[3]), .counter_chip_data_rd(stb[2]),
        .counter_chip_data_wr(stb[1]), .counter_chip_cmd_wr(stb[0]),
        .board_irq_n(board_irq_n));
    task chk(input [15:0] e, input [15:0] g);
        begin
            checks_done = checks_done + 1;
            if (e !== g) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: expected %h got %h", $time, e, g);
            end
        end
    endtask
    // Mask hides the bits the host must ignore
    task rd(input [19:0] off, input [15:0] e, input [15:0] m);
        begin
            exp_q.push_back({m, e & m});
            host_u.acc(off, 1'b0, 2'b11, 16'h0000);
        end
    endtask
    function [15:0] st_exp;
        reg irq;
        begin
            irq = (cmd1[7] & m_flag[3]) | (cmd1[6] & fne) | (cmd1[13] & m_flag[0]);
            st_exp = {~irq, m_flag[3], fne, 1'b0, run, 1'b0, m_flag[2:1], mg[6:5],
                      m_flag[0], mg[4:0]};
        end
    endfunction
    task rnd_in;
        begin
            @(posedge core_clk);
            r = $urandom;
            {fifo_d, slot, run, fne, mg} <= r[31:3];
            r = $urandom;
            {ctr_d, ctr_s} <= r;
            r = $urandom;
            din <= r[15:0];
            @(negedge core_clk);
        end
    endtask
    task rise_c2;
        begin
            @(posedge core_clk);
            c2 <= 1'b1;
            repeat (3) @(posedge core_clk);
            c2 <= 1'b0;
            @(negedge core_clk);
            m_flag[0] = 1'b1;
        end
    endtask
    task give_verdict;
        begin
            if (bad_count == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    always @(posedge core_clk) rd_pend <= host_rd;
    always @(negedge core_clk) begin
        if (host_wr || host_rd)
            stb_seen = stb;
        if (rd_pend) begin
            chk(exp_q[0][15:0], host_rdata & exp_q[0][31:16]);
            void'(exp_q.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count = bad_count + 1;
        give_verdict;
    end
    initial begin
        r = $urandom(32'h3809);
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            rnd_in;
            rd(20'h0, st_exp(), 16'hEBFF);
            host_u.idle;
        end
        for (i = 0; i < 9; i = i + 1) begin
            r = $urandom;
            host_u.acc(WOFF[i], 1'b1, 2'b11, r[15:0]);
            host_u.idle;
            if (i == 0)
                cmd1 = r[15:0];
            chk(r[15:0], wreg[i]);
        end
        rd(20'h30, ctr_d, 16'hFFFF);
        rd(20'h34, ctr_s, 16'hFFFF);
        rd(20'h38, din, 16'hFFFF);
        rd(20'h3C, 16'h0000, 16'hFFFF);
        host_u.acc(20'h3C, 1'b1, 2'b11, ~r[15:0]);
        host_u.idle;
        chk(r[15:0], wreg[8]);
        chk(16'h0000, {5'h00, stb_seen});
        for (i = 0; i < 11; i = i + 1) begin
            r = $urandom;
            if (i == 7 || i == 8)
                rd(SOFF[i], (i == 7) ? fifo_d : ctr_d, 16'hFFFF);
            else if (i == 6)
                host_u.wr8(SOFF[i], r[7:0]);
            else
                host_u.acc(SOFF[i], 1'b1, 2'b11, r[15:0]);
            host_u.idle;
            chk({5'h00, 11'h400 >> i}, {5'h00, stb_seen});
        end
        host_u.wr8(20'hC0000, r[7:0]);
        host_u.idle;
        chk({8'h00, r[7:0]}, {8'h00, tsw});
        cmd1 = 16'h2080;
        host_u.acc(20'h0, 1'b1, 2'b11, cmd1);
        host_u.idle;
        @(posedge core_clk);
        evt <= 3'b111;
        @(posedge core_clk);
        evt <= 3'b000;
        m_flag[3:1] = 3'b111;
        rise_c2;
        chk(16'h0000, {15'h0000, board_irq_n});
        rd(20'h0, st_exp(), 16'hEBFF);
        host_u.acc(20'h18, 1'b1, 2'b11, r[15:0]);
        m_flag[3:1] = 3'b000;
        rd(20'h0, st_exp(), 16'hEBFF);
        for (i = 0; i < 3; i = i + 1) begin
            host_u.idle;
            rise_c2;
            rd(20'h0, st_exp(), 16'hEBFF);
            host_u.acc((i == 0) ? 20'h40000 : WOFF[i + 3], 1'b1, 2'b11, r[15:0]);
            m_flag[0] = 1'b0;
            rd(20'h0, st_exp(), 16'hEBFF);
        end
        host_u.idle;
        // Let the read checker take the last result before closing
        @(posedge core_clk);
        give_verdict;
    end
endmodule // testbench
bind srd_slot_register_decode srd_props #(.SLOT_ADDR_W(SLOT_ADDR_W)) props_u (.core_clk,
    .resetn, .host_addr, .host_wr, .host_rd, .host_byte_en, .host_wdata, .host_rdata,
    .run_done_evt, .fifo_overflow_evt, .convert_overrun_evt, .internal_run_active,
    .digital_in_lines, .command_word_two, .acquisition_clear_strobe, .board_irq_n);
